/* File: rtl/sarcr_top.sv */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Converter enable powers the converter; clearing it shuts it off.
// R2 - Writing one to go starts a conversion; cleared at its end.
// R3 - Done flag set at finish, zero while converting, firmware writes 0.
// R4 - Clock source bit picks fast oscillator at 0, slow at 1.
// R5 - Channel codes 0-12 pick inputs, 13 reserved, 14-15 internal.
// R6 - Internal channel needs supply or external high reference. The logic does not enforce it and leaves it to software.
// R7 - 12-bit result split over high byte and low nibble, read only.
// R8 - Channel gate connects the selected input; cleared disconnects all.
// R9 - Divider field: 00 by 16, 01 by 8, 10 by 1, 11 by 2.
// R10 - External reference bit takes high reference from the shared pin.
// R11 - PWM trigger starts a conversion only while trigger enable is set.
// R12 - Reference select: 2V, 3V, 4V, supply, supply plus internal level.
// R13 - Analog-only bits isolate the digital path of their pins.
// R14 - Conversion lasts sixteen periods of converter clock over four.
// R15 - Interrupt request flag is set by hardware, software only clears.
// R16 - Interrupt enable lets the request reach the CPU; resets to zero.
module sarcr_top
  import sarcr_pkg::*;
#(
  parameter int N_EXT_CH = 13,
  parameter int RES_W = 12,
  parameter int P3_W = 2
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic fosc_tick_i,
  input wire logic flosc_tick_i,
  input wire logic pwm_trigger_i,
  input wire logic [RES_W-1:0] core_result_i,
  output logic [7:0] rdata_o,
  output logic converter_on_o,
  output logic conv_start_o,
  output logic converter_tick_o,
  output logic [N_EXT_CH-1:0] ain_select_o,
  output logic internal_level_channel_o,
  output logic external_reference_pin_o,
  output logic internal_reference_on_o,
  output logic [1:0] high_ref_level_o,
  output logic [1:0] internal_level_o,
  output logic internal_level_on_o,
  output logic [7:0] port1_analog_only_o,
  output logic [7:0] port2_analog_only_o,
  output logic [P3_W-1:0] port3_analog_only_o,
  output logic converter_irq_o,
  output logic irq_o
);
  import sarcr_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // Result split is fixed at eight high bits plus a nibble
  if (RES_W != 12) begin : g_bad_res
    $error("sarcr_top: RES_W must be 12");
  end
  if (N_EXT_CH < 1 || N_EXT_CH > 13) begin : g_bad_ch
    $error("sarcr_top: N_EXT_CH must be 1 to 13");
  end
  if (P3_W < 1 || P3_W > 8) begin : g_bad_p3
    $error("sarcr_top: P3_W must be 1 to 8");
  end
  if (int'(CONV_LAST) + 1 != CONV_TICKS) begin : g_bad_conv
    $error("sarcr_top: conversion count does not fit the counter");
  end
  if (ST_W > 8) begin : g_bad_st
    $error("sarcr_top: status must fit one byte");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] div_last(input logic [1:0] code);
    logic [3:0] v;
    v = DIV2_LAST;
    if (code == DIV16) begin
      v = DIV16_LAST;
    end else if (code == DIV8) begin
      v = DIV8_LAST;
    end else if (code == DIV1) begin
      v = DIV1_LAST;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sarcr_state_t state;
  logic conv_on;
  logic conv_go;
  logic conv_done;
  logic clk_src;
  logic [3:0] chan_sel;
  logic gate;
  logic [1:0] div_sel;
  logic ext_ref;
  logic pwm_on;
  logic [2:0] vhs;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [P3_W-1:0] p3;
  logic global_en;
  logic irq_en;
  logic irq_flag;
  logic [RES_W-1:0] result;
  logic [ST_W-1:0] st;
  logic [ST_W-1:0] mask;
  logic [3:0] pre_cnt;
  logic [5:0] conv_cnt;

  // ----------------------------------------------------------------
  // Address match
  // ----------------------------------------------------------------
  // Shared by the write strobes and the read multiplexer
  wire hit_mode = (addr_i == ADDR_MODE);
  wire hit_resh = (addr_i == ADDR_RESH);
  wire hit_rate = (addr_i == ADDR_RATE);
  wire hit_ref = (addr_i == ADDR_REF);
  wire hit_p1 = (addr_i == ADDR_P1);
  wire hit_p2 = (addr_i == ADDR_P2);
  wire hit_p3 = (addr_i == ADDR_P3);
  wire hit_interrupt_enable_zero = (addr_i == ADDR_INTERRUPT_ENABLE_ZERO);
  wire hit_interrupt_enable_two = (addr_i == ADDR_INTERRUPT_ENABLE_TWO);
  wire hit_irq2 = (addr_i == ADDR_IRQ2);
  wire hit_stat = (addr_i == ADDR_STAT);
  wire hit_mask = (addr_i == ADDR_MASK);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_mode = wr_i && hit_mode;
  wire wr_rate = wr_i && hit_rate;
  wire wr_ref = wr_i && hit_ref;
  wire wr_p1 = wr_i && hit_p1;
  wire wr_p2 = wr_i && hit_p2;
  wire wr_p3 = wr_i && hit_p3;
  wire wr_interrupt_enable_zero = wr_i && hit_interrupt_enable_zero;
  wire wr_interrupt_enable_two = wr_i && hit_interrupt_enable_two;
  wire wr_irq2 = wr_i && hit_irq2;
  wire wr_stat = wr_i && hit_stat;
  wire wr_mask = wr_i && hit_mask;

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  wire running = (state == SARCR_RUN);
  wire src_tick = clk_src ? flosc_tick_i : fosc_tick_i; // [R4]
  wire pre_wrap = (pre_cnt == div_last(div_sel)); // [R9]
  wire div_tick = running && src_tick && pre_wrap;
  // Start may come in the same write that turns the converter on
  wire on_now = wr_mode ? wdata_i[MODE_ON_BIT] : conv_on;
  wire sw_req = wr_mode && wdata_i[MODE_GO_BIT]; // [R2]
  wire pwm_req = pwm_on && pwm_trigger_i; // [R11]
  wire start_req = sw_req || pwm_req;
  wire start_ok = !running && on_now;
  wire start = start_req && start_ok;
  // Requests while busy or off are dropped and reported
  wire drop = start_req && !start_ok;
  wire finish = div_tick && (conv_cnt == CONV_LAST); // [R14]
  // Abort keeps done low and leaves the old result in place
  wire abort = running && !on_now; // [R1]
  wire done_clr = wr_mode && !wdata_i[MODE_DONE_BIT];
  wire next_go = start || (conv_go && !finish && !abort); // [R2]
  // Set wins over a clear in the same cycle
  wire next_done = finish || (conv_done && !start && !done_clr); // [R3]
  wire flag_clr = wr_irq2 && !wdata_i[IRQ2_FLAG_BIT];
  wire next_flag = finish || (irq_flag && !flag_clr); // [R15]
  wire [ST_W-1:0] st_set = {drop, finish};
  wire [ST_W-1:0] st_clr = wr_stat ? wdata_i[ST_W-1:0] : '0;
  wire [ST_W-1:0] next_st = st_set | (st & ~st_clr);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state <= SARCR_IDLE;
      pre_cnt <= '0;
      conv_cnt <= '0;
    end else begin
      case (state)
        SARCR_IDLE: begin
          // Every start counts from a fresh prescaler
          pre_cnt <= '0;
          conv_cnt <= '0;
          if (start) begin
            state <= SARCR_RUN;
          end
        end
        SARCR_RUN: begin
          if (finish || abort) begin
            state <= SARCR_IDLE;
          end
          // A divider lowered mid-run may stretch one tick to 16 counts
          if (src_tick) begin
            pre_cnt <= pre_wrap ? '0 : pre_cnt + 4'h1;
          end
          if (div_tick) begin
            conv_cnt <= conv_cnt + 6'h01; // [R14]
          end
        end
        default: begin
          state <= SARCR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      conv_on <= REG_RST[MODE_ON_BIT]; // [R1]
      conv_go <= REG_RST[MODE_GO_BIT];
      conv_done <= REG_RST[MODE_DONE_BIT];
      clk_src <= REG_RST[MODE_SRC_BIT];
      chan_sel <= REG_RST[3:0];
      gate <= REG_RST[RATE_GATE_BIT]; // [R8]
      div_sel <= REG_RST[1:0]; // [R9]
      ext_ref <= REG_RST[REF_EXT_BIT];
      pwm_on <= REG_RST[REF_PWM_BIT];
      vhs <= REG_RST[2:0];
      p1 <= REG_RST;
      p2 <= REG_RST;
      p3 <= REG_RST[P3_W-1:0];
      global_en <= REG_RST[INTERRUPT_ENABLE_ZERO_GLOBAL_BIT];
      irq_en <= REG_RST[INTERRUPT_ENABLE_TWO_CONV_BIT]; // [R16]
      irq_flag <= REG_RST[IRQ2_FLAG_BIT];
      st <= REG_RST[ST_W-1:0];
      mask <= REG_RST[ST_W-1:0];
    end else begin
      conv_go <= next_go;
      conv_done <= next_done;
      irq_flag <= next_flag;
      st <= next_st;
      if (wr_mode) begin
        conv_on <= wdata_i[MODE_ON_BIT]; // [R1]
        clk_src <= wdata_i[MODE_SRC_BIT]; // [R4]
        chan_sel <= wdata_i[CHS_LSB +: 4]; // [R5]
      end
      if (wr_rate) begin
        gate <= wdata_i[RATE_GATE_BIT];
        div_sel <= wdata_i[RATE_DIV_LSB +: 2];
      end
      if (wr_ref) begin
        ext_ref <= wdata_i[REF_EXT_BIT];
        pwm_on <= wdata_i[REF_PWM_BIT];
        vhs <= wdata_i[REF_VHS_LSB +: 3];
      end
      if (wr_p1) begin
        p1 <= wdata_i;
      end
      if (wr_p2) begin
        p2 <= wdata_i;
      end
      if (wr_p3) begin
        p3 <= wdata_i[P3_W-1:0];
      end
      if (wr_interrupt_enable_zero) begin
        global_en <= wdata_i[INTERRUPT_ENABLE_ZERO_GLOBAL_BIT];
      end
      if (wr_interrupt_enable_two) begin
        irq_en <= wdata_i[INTERRUPT_ENABLE_TWO_CONV_BIT];
      end
      if (wr_mask) begin
        mask <= wdata_i[ST_W-1:0];
      end
    end
  end

  // Result holds no reset value; unknown until the first conversion
  always_ff @(posedge core_clk_i) begin
    if (finish) begin
      result <= core_result_i; // [R7]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reads have no side effects; status clears only by a write
  wire [7:0] rd_mode = {conv_on, conv_go, conv_done, clk_src, chan_sel};
  wire [7:0] rd_resh = result[RES_W-1:4]; // [R7]
  wire [7:0] rd_rate = {1'b0, gate, div_sel, result[3:0]}; // [R7]
  wire [7:0] rd_ref = {ext_ref, 2'b00, pwm_on, 1'b0, vhs};
  wire [7:0] rd_p3 = {{(8 - P3_W){1'b0}}, p3};
  wire [7:0] rd_interrupt_enable_zero = {global_en, 7'h00};
  wire [7:0] rd_interrupt_enable_two = {7'h00, irq_en};
  wire [7:0] rd_irq2 = {7'h00, irq_flag};
  wire [7:0] rd_st = {{(8 - ST_W){1'b0}}, st};
  wire [7:0] rd_mask = {{(8 - ST_W){1'b0}}, mask};
  wire [7:0] rd_mux =
    hit_mode ? rd_mode :
    hit_resh ? rd_resh :
    hit_rate ? rd_rate :
    hit_ref ? rd_ref :
    hit_p1 ? p1 :
    hit_p2 ? p2 :
    hit_p3 ? rd_p3 :
    hit_interrupt_enable_zero ? rd_interrupt_enable_zero :
    hit_interrupt_enable_two ? rd_interrupt_enable_two :
    hit_irq2 ? rd_irq2 :
    hit_stat ? rd_st :
    hit_mask ? rd_mask : 8'h00;
  wire [7:0] next_rdata = rd_i ? rd_mux : 8'h00;

  // ----------------------------------------------------------------
  // Analog control decode
  // ----------------------------------------------------------------
  logic [N_EXT_CH-1:0] next_ain;
  for (genvar i = 0; i < N_EXT_CH; i++) begin : g_ain
    assign next_ain[i] = gate && (chan_sel == 4'(i)); // [R5] [R8]
  end
  // Code 13 matches no input and leaves every channel open
  wire next_int_ch = gate && (chan_sel >= CHS_INT_MIN); // [R5] [R8]
  wire vhs_int = vhs[2] && (vhs != VHS_RESERVED);
  // Reserved 111 falls back to the supply reference
  wire [1:0] next_high = vhs[2] ? LVL_VDD : vhs[1:0]; // [R12]
  wire next_int_on = vhs_int; // [R12]
  // Mis-set references under the internal channel are software's fault
  wire next_ext_pin = ext_ref; // [R10]

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      converter_on_o <= 1'b0;
      conv_start_o <= 1'b0;
      converter_tick_o <= 1'b0;
      ain_select_o <= '0;
      internal_level_channel_o <= 1'b0;
      external_reference_pin_o <= 1'b0;
      internal_reference_on_o <= 1'b0;
      high_ref_level_o <= 2'h0;
      internal_level_o <= 2'h0;
      internal_level_on_o <= 1'b0;
      port1_analog_only_o <= 8'h00;
      port2_analog_only_o <= 8'h00;
      port3_analog_only_o <= '0;
      converter_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      // Powered in the same cycle as a start given with the enable
      converter_on_o <= on_now; // [R1]
      conv_start_o <= start; // [R2] [R11]
      converter_tick_o <= div_tick;
      ain_select_o <= next_ain;
      internal_level_channel_o <= next_int_ch;
      external_reference_pin_o <= next_ext_pin; // [R10]
      internal_reference_on_o <= !next_ext_pin; // [R10]
      high_ref_level_o <= next_high;
      internal_level_o <= vhs[1:0];
      internal_level_on_o <= next_int_on;
      port1_analog_only_o <= p1; // [R13]
      port2_analog_only_o <= p2; // [R13]
      port3_analog_only_o <= p3; // [R13]
      // Interrupt outputs follow their flags one cycle later
      converter_irq_o <= irq_flag && irq_en && global_en; // [R16]
      irq_o <= |(st & mask);
    end
  end
endmodule
`default_nettype wire

/* File: pkg/sarcr_pkg.sv */
`default_nettype none
package sarcr_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE_TWO = 8'h9A;
  localparam logic [7:0] ADDR_P1 = 8'h9F;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE_ZERO = 8'hA8;
  localparam logic [7:0] ADDR_IRQ2 = 8'hBF;
  localparam logic [7:0] ADDR_MODE = 8'hD2;
  localparam logic [7:0] ADDR_RESH = 8'hD3;
  localparam logic [7:0] ADDR_RATE = 8'hD4;
  localparam logic [7:0] ADDR_REF = 8'hD5;
  localparam logic [7:0] ADDR_P2 = 8'hD6;
  localparam logic [7:0] ADDR_P3 = 8'hD7;
  localparam logic [7:0] ADDR_STAT = 8'hE0;
  localparam logic [7:0] ADDR_MASK = 8'hE1;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_ON_BIT = 7;
  localparam int MODE_GO_BIT = 6;
  localparam int MODE_DONE_BIT = 5;
  localparam int MODE_SRC_BIT = 4;
  localparam int CHS_LSB = 0;
  localparam int RATE_GATE_BIT = 6;
  localparam int RATE_DIV_LSB = 4;
  localparam int REF_EXT_BIT = 7;
  localparam int REF_PWM_BIT = 4;
  localparam int REF_VHS_LSB = 0;
  localparam int INTERRUPT_ENABLE_ZERO_GLOBAL_BIT = 7;
  localparam int INTERRUPT_ENABLE_TWO_CONV_BIT = 0;
  localparam int IRQ2_FLAG_BIT = 0;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_DROP_BIT = 1;
  localparam int ST_W = 2;
  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] CHS_INT_MIN = 4'hE;
  localparam logic [1:0] DIV16 = 2'h0;
  localparam logic [1:0] DIV8 = 2'h1;
  localparam logic [1:0] DIV1 = 2'h2;
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [3:0] DIV8_LAST = 4'h7;
  localparam logic [3:0] DIV1_LAST = 4'h0;
  localparam logic [3:0] DIV2_LAST = 4'h1;
  localparam logic [2:0] VHS_RESERVED = 3'h7;
  localparam logic [1:0] LVL_VDD = 2'h3;
  // ----------------------------------------------------------------
  // Conversion timing, in divided converter clock periods
  // ----------------------------------------------------------------
  localparam int CONV_QUARTER_PERIODS = 16;
  localparam int CLKS_PER_QUARTER = 4;
  localparam int CONV_TICKS = CONV_QUARTER_PERIODS * CLKS_PER_QUARTER;
  localparam logic [5:0] CONV_LAST = 6'(CONV_TICKS - 1);
  typedef enum logic {SARCR_IDLE = 1'b0, SARCR_RUN = 1'b1} sarcr_state_t;
endpackage
`default_nettype wire

/* File: verification/sarcr_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sarcr_chk
  import sarcr_pkg::*;
#(
  parameter int N_EXT_CH = 13
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic pwm_trigger_i,
  input wire logic [7:0] rdata_o,
  input wire logic converter_on_o,
  input wire logic conv_start_o,
  input wire logic [N_EXT_CH-1:0] ain_select_o,
  input wire logic internal_level_channel_o,
  input wire logic external_reference_pin_o,
  input wire logic internal_reference_on_o,
  input wire logic [1:0] high_ref_level_o,
  input wire logic internal_level_on_o,
  input wire logic [7:0] port1_analog_only_o
);
  // ----------------------------------------------------------------
  // Port-level properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_rdata_quiet: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
  chk_start_cause: assert property (
    conv_start_o |-> $past(pwm_trigger_i || wr_i && addr_i == ADDR_MODE
      && wdata_i[7:6] == 2'h3)) else $error("start without request");
  chk_start_pulse: assert property (
    conv_start_o |=> !conv_start_o) else $error("start pulse too long");
  chk_start_powered: assert property (
    conv_start_o |-> converter_on_o) else $error("start while off");
  chk_gate_off: assert property (
    $past(wr_i && addr_i == ADDR_RATE && !wdata_i[6]) |-> ##1
      (ain_select_o == '0 && !internal_level_channel_o))
    else $error("input connected with gate off");
  chk_one_channel: assert property (
    $onehot0({ain_select_o, internal_level_channel_o}))
    else $error("several inputs connected");
  chk_ref_pin: assert property (
    $past(wr_i && addr_i == ADDR_REF) |-> ##1
      external_reference_pin_o == $past(wdata_i[7], 2))
    else $error("reference pin not following write");
  chk_ref_inverse: assert property (
    $past(nrst_i) && $past(nrst_i, 2) |->
      internal_reference_on_o != external_reference_pin_o)
    else $error("internal and external reference both on or off");
  chk_level_supply: assert property (
    internal_level_on_o |-> high_ref_level_o == LVL_VDD)
    else $error("internal level without supply reference");
  chk_port1_copy: assert property (
    $past(wr_i && addr_i == ADDR_P1) |-> ##1
      port1_analog_only_o == $past(wdata_i, 2))
    else $error("port1 analog bits not following write");
endmodule
bind sarcr_top sarcr_chk #(.N_EXT_CH(N_EXT_CH)) sarcr_chk_i (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .pwm_trigger_i(pwm_trigger_i), .rdata_o(rdata_o),
  .converter_on_o(converter_on_o), .conv_start_o(conv_start_o),
  .ain_select_o(ain_select_o),
  .internal_level_channel_o(internal_level_channel_o),
  .external_reference_pin_o(external_reference_pin_o),
  .internal_reference_on_o(internal_reference_on_o),
  .high_ref_level_o(high_ref_level_o),
  .internal_level_on_o(internal_level_on_o),
  .port1_analog_only_o(port1_analog_only_o)
);
`default_nettype wire

/* File: verification/sarcr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sarcr_core_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [11:0] level_i,
  output logic [11:0] result_o
);
  logic [6:0] step;
  // Result churns each tick until the last steps: an early latch
  // picks up garbage instead of the level.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      step <= 7'h40;
      result_o <= 12'h5A3;
    end else if (start_i) begin
      step <= 7'h00;
    end else if (tick_i && step != 7'h40) begin
      step <= step + 7'h01;
      result_o <= (step > 7'h3A) ? level_i : ~result_o;
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_sarcr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sarcr_top;
  import sarcr_pkg::*;
  localparam int LIMIT = 20000;
  logic clk, nrst, wr, rd, fosc, flosc, pwm, rd_seen;
  logic on, start, tick, ich, xref, iref, lon, cirq, irq;
  logic [7:0] addr, wdata, rdata, p1, p2, d;
  logic [1:0] hlvl, p3, ilvl;
  logic [12:0] ain;
  logic [11:0] level, result;
  logic [7:0] expq[$];
  logic [7:0] zl[10] = '{ADDR_P1, ADDR_MODE, ADDR_REF, ADDR_P2, ADDR_P3,
    ADDR_INTERRUPT_ENABLE_ZERO, ADDR_INTERRUPT_ENABLE_TWO, ADDR_IRQ2, ADDR_STAT, 8'h00};
  int dv[6] = '{0, 1, 2, 3, 3, 2};
  int nt[6] = '{16, 8, 1, 2, 2, 1};
  int mismatches, checks, cyc, t0, seed = 32'hbdcd;

  sarcr_top sarcr_top_i (
    .core_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .fosc_tick_i(fosc), .flosc_tick_i(flosc),
    .pwm_trigger_i(pwm), .core_result_i(result), .rdata_o(rdata),
    .converter_on_o(on), .conv_start_o(start), .converter_tick_o(tick),
    .ain_select_o(ain), .internal_level_channel_o(ich),
    .external_reference_pin_o(xref), .internal_reference_on_o(iref),
    .high_ref_level_o(hlvl), .internal_level_o(ilvl),
    .internal_level_on_o(lon), .port1_analog_only_o(p1),
    .port2_analog_only_o(p2), .port3_analog_only_o(p3),
    .converter_irq_o(cirq), .irq_o(irq)
  );
  sarcr_core_model sarcr_core_model_i (.clk_i(clk), .nrst_i(nrst),
    .start_i(start), .tick_i(tick), .level_i(level), .result_o(result));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [19:0] got, logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr8(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic pulse_pwm;
    @(posedge clk);
    pwm <= 1'b1;
    @(posedge clk);
    pwm <= 1'b0;
  endtask
  // Second start mid-run must be dropped and flagged in status bit1
  task automatic conv(int k);
    logic [7:0] mv;
    int span, tol;
    mv = 8'hC5 | ((k == 4) ? 8'h10 : 8'h00);
    span = 64 * nt[k] * ((k == 4) ? 3 : 2);
    tol = span / 64 + 4;
    level <= 12'($random(seed));
    wr8(ADDR_RATE, 8'h40 | 8'(dv[k] << 4));
    if (k == 5) begin
      wr8(ADDR_MODE, mv & 8'hBF);
      pulse_pwm();
    end else
      wr8(ADDR_MODE, mv);
    t0 = cyc;
    rd8(ADDR_MODE, mv);
    wr8(ADDR_MODE, mv);
    while (irq !== 1'b1 && cyc < t0 + span + 50)
      @(posedge clk);
    chk("span", 20'(cyc - t0 >= span - tol && cyc - t0 <= span + tol),
      20'h1);
    @(negedge clk);
    chk("irqs", {cirq, irq, on}, 3'h7);
    rd8(ADDR_MODE, mv ^ 8'h60);
    rd8(ADDR_RESH, level[11:4]);
    rd8(ADDR_RATE, 8'h40 | 8'(dv[k] << 4) | 8'(level[3:0]));
    rd8(ADDR_STAT, 8'h03);
    wr8(ADDR_STAT, 8'h03);
    wr8(ADDR_IRQ2, 8'h00);
    wr8(ADDR_MODE, mv & 8'h9F);
    rd8(ADDR_MODE, mv & 8'h9F);
    @(negedge clk);
    chk("irqs", {cirq, irq}, 2'h0);
  endtask

  // ----------------------------------------------------------------
  // Clock, oscillators, read monitor and stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fosc <= (cyc % 2 == 0);
    flosc <= (cyc % 3 == 0);
    if (rd_seen)
      chk("rdata", rdata, expq.pop_front());
    rd_seen <= rd;
    if (cyc == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    {nrst, wr, rd, pwm, fosc, flosc, rd_seen} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    level = 12'h000;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    foreach (zl[i])
      rd8(zl[i], 8'h00);
    chk("ain", {ich, ain}, 14'h0);
    repeat (4) begin
      d = 8'($random(seed));
      wr8(ADDR_P1, d);
      wr8(ADDR_P2, ~d);
      wr8(ADDR_P3, d);
      wr8(ADDR_REF, d);
      wr8(ADDR_IRQ2, 8'hFF);
      rd8(ADDR_P3, d & 8'h03);
      rd8(ADDR_REF, d & 8'h97);
      rd8(ADDR_IRQ2, 8'h00);
      @(negedge clk);
      chk("ports", {p3, p1, p2}, {d[1:0], d, ~d});
      chk("xref", {xref, iref}, {d[7], ~d[7]});
      chk("level", {hlvl, lon, ilvl}, {d[2] ? 2'h3 : d[1:0],
        d[2] && d[1:0] != 2'h3, d[1:0]});
    end
    wr8(ADDR_REF, 8'h05);
    for (int c = 0; c < 16; c++) begin
      wr8(ADDR_RATE, 8'h40);
      wr8(ADDR_MODE, 8'(c));
      repeat (2) @(negedge clk);
      chk("chan", {ich, ain}, c > 13 ? 14'h2000 : 14'(c < 13) << c);
      wr8(ADDR_RATE, 8'h00);
      repeat (2) @(negedge clk);
      chk("gate", {ich, ain}, 14'h0);
    end
    wr8(ADDR_INTERRUPT_ENABLE_TWO, 8'h01);
    wr8(ADDR_INTERRUPT_ENABLE_ZERO, 8'h80);
    wr8(ADDR_MASK, 8'h01);
    rd8(ADDR_INTERRUPT_ENABLE_TWO, 8'h01);
    for (int k = 0; k < 6; k++) begin
      if (k == 5) begin
        wr8(ADDR_MODE, 8'h85);
        pulse_pwm();
        repeat (4) @(posedge clk);
        rd8(ADDR_MODE, 8'h85);
        wr8(ADDR_REF, 8'h13);
      end
      conv(k);
    end
    wr8(ADDR_MODE, 8'hC0);
    wr8(ADDR_MODE, 8'h00);
    rd8(ADDR_MODE, 8'h00);
    repeat (300) @(posedge clk);
    rd8(ADDR_STAT, 8'h00);
    chk("on", on, 1'b0);
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
